// ===== rtl/hotplug_defines.svh
// Notes on behaviour
// - attention button press sets sticky flag at status bit 0
// - power fault reported by slot power controller sets sticky flag bit 1
// - retention latch sensor change in either direction sets sticky flag bit 2
// - card presence change sets sticky flag bit 3
// - command finishing sets sticky done flag bit 4; already set stays set
// - a write to slot control taken while idle is one command; writes taken while busy merge into one
// - done flag waits until all resulting expander transactions are finished
// - live latch sensor state at read-only bit 5, 0 closed, 1 open
// - live card presence at read-only bit 6, 0 empty, 1 present, default 1
// - interlock status at read-only bit 7, 0 disengaged, 1 engaged, if fitted
// - toggle of link active indication sets sticky flag bit 8
// - interrupt only for enabled latched events and only with master enable set
`ifndef HOTPLUG_DEFINES_SVH
`define HOTPLUG_DEFINES_SVH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define IDX_SLOT_CONTROL      10'h058
`define IDX_SLOT_STATUS       10'h05A
`define IDX_DEV_CAP2          10'h064
`define IDX_DEV_CTL2          10'h068
`define IDX_DEV_STS2          10'h06A
`define IDX_LINK_CAP2         10'h06C

// ***************************************************************
// slot status fields
// ***************************************************************
`define ST_BUTTON             0
`define ST_POWER_FAULT        1
`define ST_LATCH_CHANGED      2
`define ST_PRESENCE_CHANGED   3
`define ST_CMD_DONE           4
`define ST_LATCH_STATE        5
`define ST_CARD_PRESENT       6
`define ST_INTERLOCK          7
`define ST_LINK_CHANGED       8
`define ST_STICKY_MASK        16'h011F

// ***************************************************************
// slot control fields
// ***************************************************************
`define CT_BUTTON_EN          0
`define CT_POWER_FAULT_EN     1
`define CT_LATCH_EN           2
`define CT_PRESENCE_EN        3
`define CT_CMD_DONE_EN        4
`define CT_MASTER_EN          5
`define CT_ATTN_IND_LSB       6
`define CT_ATTN_IND_MSB       7
`define CT_PWR_IND_LSB        8
`define CT_PWR_IND_MSB        9
`define CT_POWER_OFF          10
`define CT_INTERLOCK_TOGGLE   11
`define CT_LINK_EN            12
`define CT_WRITABLE_MASK      16'h1FFF
`define CT_RESET              16'h01C0
`define CT_READ_MASK          16'h17FF

// ***************************************************************
// reset values
// ***************************************************************
`define PINS_RESET            5'h02   // card_present only: no false fault or presence edge
`define ZERO_WORD             32'h00000000

`endif

// ===== rtl/hotplug_pkg.sv
package hotplug_pkg;

   // ***************************************************************
   // slot side levels, seen through the io expanders
   // ***************************************************************
   typedef struct packed {
      logic button;        // attention button held
      logic power_fault;   // power controller fault
      logic latch_open;    // retention_latch sensor, 1 = open
      logic card_present;  // presence detect, 1 = card
      logic interlock;     // interlock engaged
   } slot_pins_type;

   // ***************************************************************
   // one command handed to the expander sequencer
   // ***************************************************************
   typedef struct packed {
      logic [15:0] control;   // full slot control image after the write
      logic [15:0] changed;   // fields touched by this write
   } command_type;

   typedef enum logic [0:0] {
      CMD_IDLE = 1'b0,
      CMD_BUSY = 1'b1
   } cmd_state_type;

endpackage : hotplug_pkg

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser with change detect on the settled side
module pin_sync #(
   parameter int unsigned      W         = 1,
   parameter logic [W-1:0]     RESET_VAL = '0
) (
   input  wire logic           mclk,
   input  wire logic           nrst,
   input  wire logic [W-1:0]   async_d,
   output logic      [W-1:0]   level,
   output logic      [W-1:0]   changed
);

   logic [W-1:0] meta_q;
   logic [W-1:0] level_q;
   logic [W-1:0] prev_q;

   // meta_q feeds level_q only
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_q  <= RESET_VAL;
         level_q <= RESET_VAL;
         prev_q  <= RESET_VAL;
      end else begin
         meta_q  <= async_d;
         level_q <= meta_q;
         prev_q  <= level_q;
      end
   end

   assign level   = level_q;
   assign changed = level_q ^ prev_q;

endmodule : pin_sync
`default_nettype wire

// ===== rtl/sticky_flags.sv
`timescale 1ns/10ps
`default_nettype none
// write-one-to-clear flags; a set in the clearing cycle wins
module sticky_flags #(
   parameter int unsigned      W = 1
) (
   input  wire logic           mclk,
   input  wire logic           nrst,
   input  wire logic [W-1:0]   set,
   input  wire logic [W-1:0]   clr,
   output logic      [W-1:0]   flags
);

   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;

   assign flags_d = (flags_q & ~clr) | set;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

endmodule : sticky_flags
`default_nettype wire

// ===== rtl/hotplug_slot_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "hotplug_defines.svh"
// slot event status for one downstream port, wishbone classic slave
module hotplug_slot_status #(
   parameter bit               INTERLOCK_PRESENT = 1'b1
) (
   input  wire logic                          mclk,
   input  wire logic                          nrst,
   // wishbone classic slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [11:0]                   wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   // slot levels from the expander inputs, asynchronous
   input  wire hotplug_pkg::slot_pins_type    slot_pins,
   // link layer state, same clock
   input  wire logic                          link_active_indication,
   // command hand-off to the expander sequencer
   output hotplug_pkg::command_type           cmd_out,
   output logic                               cmd_start,
   input  wire logic                          cmd_done,
   // level interrupt
   output logic                               hotplug_irq
);

   // ***************************************************************
   // slot pin synchronisation
   // ***************************************************************
   hotplug_pkg::slot_pins_type pins_now;
   hotplug_pkg::slot_pins_type pins_edge;

   pin_sync #(
      .W         (5),
      .RESET_VAL (`PINS_RESET)
   ) u_pin_sync (
      .mclk    (mclk),
      .nrst    (nrst),
      .async_d (slot_pins),
      .level   (pins_now),
      .changed (pins_edge)
   );

   // ***************************************************************
   // link active edge, already on mclk
   // ***************************************************************
   logic link_prev_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         link_prev_q <= 1'b0;
      end else begin
         link_prev_q <= link_active_indication;
      end
   end

   wire link_toggle = link_active_indication ^ link_prev_q;

   // ***************************************************************
   // bus decode
   // ***************************************************************
   logic        ack_q;
   logic [31:0] rdata_q;

   wire       bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
   wire       bus_wr    = bus_req & wb_we_i;
   wire [9:0] reg_idx   = wb_adr_i[11:2];
   wire       hit_ctl   = (reg_idx == `IDX_SLOT_CONTROL);
   wire       hit_sts   = (reg_idx == `IDX_SLOT_STATUS);
   wire       hit_empty = (reg_idx == `IDX_DEV_CAP2) |
                          (reg_idx == `IDX_DEV_CTL2) |
                          (reg_idx == `IDX_DEV_STS2) |
                          (reg_idx == `IDX_LINK_CAP2);

   // byte enables widened to the 16-bit registers
   wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [15:0] wr_bits   = wb_dat_i[15:0] & lane_mask;

   // ***************************************************************
   // slot control register, one command per write taken while idle
   // ***************************************************************
   logic [15:0] ctl_q;
   logic [15:0] ctl_d;
   logic        ctl_wr;

   assign ctl_wr = bus_wr & hit_ctl & (|wb_sel_i[1:0]);
   assign ctl_d  = ((ctl_q & ~lane_mask) | wr_bits) & `CT_WRITABLE_MASK;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctl_q <= `CT_RESET;
      end else if (ctl_wr) begin
         ctl_q <= ctl_d;
      end
   end

   // ***************************************************************
   // command sequencing: one start, one completion; writes taken while busy share one start
   // ***************************************************************
   hotplug_pkg::cmd_state_type cmd_state_q;
   hotplug_pkg::cmd_state_type cmd_state_d;
   hotplug_pkg::command_type   cmd_q;
   logic                       start_q;
   logic                       pending_q;
   logic                       cmd_finish;

   // a write landing while busy is queued; further writes while busy merge into it
   always_comb begin
      cmd_state_d = cmd_state_q;
      cmd_finish  = 1'b0;
      case (cmd_state_q)
         hotplug_pkg::CMD_IDLE: begin
            if (start_q) begin
               cmd_state_d = hotplug_pkg::CMD_BUSY;
            end
         end
         hotplug_pkg::CMD_BUSY: begin
            if (cmd_done) begin
               cmd_finish  = 1'b1;
               cmd_state_d = hotplug_pkg::CMD_IDLE;
            end
         end
         default: begin
            cmd_state_d = hotplug_pkg::CMD_IDLE;
         end
      endcase
   end

   wire can_launch = (cmd_state_q == hotplug_pkg::CMD_IDLE) & ~start_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cmd_state_q <= hotplug_pkg::CMD_IDLE;
      end else begin
         cmd_state_q <= cmd_state_d;
      end
   end

   // pending holds a write taken while the sequencer is busy
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pending_q <= 1'b0;
      end else if (ctl_wr & ~can_launch) begin
         pending_q <= 1'b1;
      end else if (can_launch) begin
         pending_q <= 1'b0;
      end
   end

   wire launch = can_launch & (ctl_wr | pending_q);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         start_q <= 1'b0;
         cmd_q   <= '0;
      end else begin
         start_q <= launch;
         if (launch) begin
            cmd_q.control <= ctl_wr ? ctl_d : ctl_q;
            cmd_q.changed <= ctl_wr ? (ctl_d ^ ctl_q) | lane_mask : `CT_WRITABLE_MASK;
         end
      end
   end

   assign cmd_start = start_q;
   assign cmd_out   = cmd_q;

   // ***************************************************************
   // sticky event flags
   // ***************************************************************
   logic [15:0] flag_set;
   logic [15:0] flag_clr;
   logic [15:0] flags;

   always_comb begin
      flag_set                       = 16'h0000;
      flag_set[`ST_BUTTON]           = pins_edge.button & pins_now.button;
      flag_set[`ST_POWER_FAULT]      = pins_now.power_fault;
      flag_set[`ST_LATCH_CHANGED]    = pins_edge.latch_open;
      flag_set[`ST_PRESENCE_CHANGED] = pins_edge.card_present;
      flag_set[`ST_CMD_DONE]         = cmd_finish;
      flag_set[`ST_LINK_CHANGED]     = link_toggle;
   end

   // clears only on the sticky positions, lanes honoured
   assign flag_clr = (bus_wr & hit_sts) ? (wr_bits & `ST_STICKY_MASK) : 16'h0000;

   sticky_flags #(
      .W (16)
   ) u_sticky_flags (
      .mclk  (mclk),
      .nrst  (nrst),
      .set   (flag_set & `ST_STICKY_MASK),
      .clr   (flag_clr),
      .flags (flags)
   );

   // ***************************************************************
   // slot status read image
   // ***************************************************************
   logic [15:0] status_img;

   always_comb begin
      status_img                   = flags & `ST_STICKY_MASK;
      status_img[`ST_LATCH_STATE]  = pins_now.latch_open;
      status_img[`ST_CARD_PRESENT] = pins_now.card_present;
      status_img[`ST_INTERLOCK]    = INTERLOCK_PRESENT & pins_now.interlock;
   end

   // ***************************************************************
   // interrupt: per-event enables under the master enable
   // ***************************************************************
   logic [15:0] irq_mask;
   logic        irq_q;

   always_comb begin
      irq_mask                       = 16'h0000;
      irq_mask[`ST_BUTTON]           = ctl_q[`CT_BUTTON_EN];
      irq_mask[`ST_POWER_FAULT]      = ctl_q[`CT_POWER_FAULT_EN];
      irq_mask[`ST_LATCH_CHANGED]    = ctl_q[`CT_LATCH_EN];
      irq_mask[`ST_PRESENCE_CHANGED] = ctl_q[`CT_PRESENCE_EN];
      irq_mask[`ST_CMD_DONE]         = ctl_q[`CT_CMD_DONE_EN];
      irq_mask[`ST_LINK_CHANGED]     = ctl_q[`CT_LINK_EN];
   end

   wire irq_d = ctl_q[`CT_MASTER_EN] & (|(flags & irq_mask));

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign hotplug_irq = irq_q;

   // ***************************************************************
   // read mux and acknowledge
   // ***************************************************************
   // interlock toggle is a write-only action, it never reads back
   wire [31:0] ctl_img = {16'h0000, ctl_q & `CT_READ_MASK};
   wire [31:0] sts_img = {16'h0000, status_img};
   // empty second-generation words decode explicitly and read zero
   wire [31:0] rd_mux  = hit_ctl   ? ctl_img :
                         hit_sts   ? sts_img :
                         hit_empty ? `ZERO_WORD :
                         `ZERO_WORD;

   // one wait state; unmapped addresses ack with zero data
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ack_q   <= 1'b0;
         rdata_q <= `ZERO_WORD;
      end else begin
         ack_q   <= bus_req;
         rdata_q <= (bus_req & ~wb_we_i) ? rd_mux : `ZERO_WORD;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

endmodule : hotplug_slot_status
`default_nettype wire

// ===== dv/hotplug_slot_status_props.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// bus and command hand-off checks, seen from the top ports only
// ***************************************************************
module hotplug_slot_status_props (
   input wire logic                      mclk,
   input wire logic                      nrst,
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_we_i,
   input wire logic [11:0]               wb_adr_i,
   input wire logic [31:0]               wb_dat_o,
   input wire logic                      wb_ack_o,
   input wire hotplug_pkg::command_type  cmd_out,
   input wire logic                      cmd_start
);
   // read answers sorted by target; only status and control hold data
   wire rd_ack     = wb_ack_o && !wb_we_i;
   wire at_status  = (wb_adr_i[11:2] == 10'h05A);
   wire at_control = (wb_adr_i[11:2] == 10'h058);

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after take");
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_request: assert property (wb_ack_o |-> $past(wb_stb_i) && wb_cyc_i)
      else $error("ack without a request");
   a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data not zero outside ack");
   a_status_reserved_zero: assert property (rd_ack && at_status |-> wb_dat_o[31:9] == 23'h0)
      else $error("status reserved bits not zero");
   a_other_regs_zero: assert property (rd_ack && !at_status && !at_control |-> wb_dat_o == '0)
      else $error("empty register read not zero");
   a_start_spacing: assert property (cmd_start |=> !cmd_start [*2])
      else $error("command starts too close");
   a_cmd_held: assert property (!cmd_start |-> $stable(cmd_out))
      else $error("command image moved without start");
endmodule : hotplug_slot_status_props
`default_nettype wire

// ===== dv/slot_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// slot hardware behind the expanders: answers commands, owns interlock
// ***************************************************************
module slot_model (
   input wire logic                      mclk,
   input wire logic                      nrst,
   input wire hotplug_pkg::command_type  cmd_out,
   input wire logic                      cmd_start,
   input wire logic [7:0]                lat,
   input wire hotplug_pkg::slot_pins_type lvl,
   output logic                          cmd_done,
   output hotplug_pkg::slot_pins_type    slot_pins
);
   logic [7:0] cnt_q;
   logic       busy_q;
   logic       lock_q;

   // expander traffic takes lat cycles; done only after the last one
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q    <= 8'h00;
         busy_q   <= 1'b0;
         lock_q   <= 1'b0;
         cmd_done <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         if (cmd_start) begin
            busy_q <= 1'b1;
            cnt_q  <= lat;
         end else if (busy_q && cnt_q == 8'h00) begin
            busy_q   <= 1'b0;
            cmd_done <= 1'b1;
            lock_q   <= lock_q ^ (cmd_out.control[11] & cmd_out.changed[11]);
         end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

   // bench sets the levels; interlock comes from the toggle command
   assign slot_pins = {lvl[4:1], lock_q};
endmodule : slot_model
`default_nettype wire

// ===== dv/hotplug_slot_status_bench.sv
`timescale 1ns/10ps
`default_nettype none
module hotplug_slot_status_bench;
   logic                       mclk, nrst, cyc, stb, we, link, cmd_start, cmd_done, irq, ack;
   logic [11:0]                adr;
   logic [3:0]                 sel;
   logic [31:0]                wdat, rdat, q;
   logic [7:0]                 lat;
   hotplug_pkg::slot_pins_type lvl, pins;
   hotplug_pkg::command_type   cmd_out;
   int                         num_errors, comparisons, starts;
   logic [11:0]                other_regs [5] = '{12'h190, 12'h1A0, 12'h1A8, 12'h1B0, 12'h200};
   logic [31:0]                masked_ctl [2] = '{32'h00000010, 32'h00000020};

   always #12.5 mclk = !mclk;

   // commands issued since reset, one per cmd_start pulse; control writes taken while busy share one
   always @(posedge mclk) if (cmd_start === 1'b1) starts++;

   hotplug_slot_status dut (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .slot_pins(pins), .link_active_indication(link), .cmd_out(cmd_out),
      .cmd_start(cmd_start), .cmd_done(cmd_done), .hotplug_irq(irq));
   slot_model partner (.mclk(mclk), .nrst(nrst), .cmd_out(cmd_out), .cmd_start(cmd_start),
      .lat(lat), .lvl(lvl), .cmd_done(cmd_done), .slot_pins(pins));

   // ***************************************************************
   // verdict, compare and bus tasks
   // ***************************************************************
   task automatic complete_run;
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // classic cycle: request held until ack is sampled, then released
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= 4'h3;
      adr  <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         num_errors++;
         complete_run();
      end
   endtask : bus

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk($sformatf("reg %h", a), q, e);
   endtask : rc

   // polls status until the completion flag shows, bounded
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         bus(1'b0, 12'h168, 32'h00000000);
         n++;
      end while (q[4] !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         complete_run();
      end
   endtask : wait_done

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      cyc  = 1'b0;
      stb  = 1'b0;
      we   = 1'b0;
      adr  = 12'h000;
      sel  = 4'h3;
      wdat = 32'h00000000;
      link = 1'b0;
      lat  = 8'h01;
      lvl  = 5'b00010;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      rc(12'h168, 32'h00000040);
      rc(12'h160, 32'h000001C0);
      foreach (other_regs[i]) begin
         bus(1'b1, other_regs[i], 32'hFFFFFFFF);
         rc(other_regs[i], 32'h00000000);
      end
      bus(1'b1, 12'h168, 32'h0000FE00);
      rc(12'h168, 32'h00000040);
      // press, fault, open latch, pull card, link up all at once
      lvl  <= 5'b11100;
      link <= 1'b1;
      repeat (6) @(posedge mclk);
      rc(12'h168, 32'h0000012F);
      bus(1'b1, 12'h168, 32'h00000105);
      rc(12'h168, 32'h0000002A);
      bus(1'b1, 12'h168, 32'h00000000);
      rc(12'h168, 32'h0000002A);
      bus(1'b1, 12'h168, 32'h0000000A);
      rc(12'h168, 32'h00000022);
      // reverse directions: release, close latch, card back, link down
      lvl  <= 5'b00010;
      link <= 1'b0;
      repeat (6) @(posedge mclk);
      rc(12'h168, 32'h0000014E);
      bus(1'b1, 12'h168, 32'h0000010E);
      rc(12'h168, 32'h00000040);
      // slow command with completion interrupt enabled
      lat <= 8'h14;
      bus(1'b1, 12'h160, 32'h00000030);
      rc(12'h168, 32'h00000040);
      wait_done();
      repeat (2) @(posedge mclk);
      chk("irq", irq, 1'b1);
      chk("starts", starts, 32'h1);
      bus(1'b1, 12'h168, 32'h00000010);
      repeat (2) @(posedge mclk);
      chk("irq", irq, 1'b0);
      // master enable off, then source enable off: no interrupt
      foreach (masked_ctl[i]) begin
         lat <= 8'h01;
         bus(1'b1, 12'h160, masked_ctl[i]);
         wait_done();
         repeat (3) @(posedge mclk);
         chk("irq", irq, 1'b0);
         bus(1'b1, 12'h168, 32'h00000010);
      end
      bus(1'b1, 12'h160, 32'h00000800);
      wait_done();
      repeat (5) @(posedge mclk);
      rc(12'h168, 32'h000000D0);
      chk("starts", starts, 32'h4);
      complete_run();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      complete_run();
   end
endmodule : hotplug_slot_status_bench

bind hotplug_slot_status hotplug_slot_status_props props (.mclk(mclk), .nrst(nrst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_out(cmd_out), .cmd_start(cmd_start));
`default_nettype wire
